// [src/smr_regs.sv]
// smr_regs: modem signal register, station address filter and receive buffer descriptors
`timescale 1ns/1ns
module smr_regs (
  input wire logic sys_clk,
  input wire logic arst_n,
  // avalon-mm slave
  // word addressed; every access takes one wait state
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // modem lines
  // inputs are asynchronous levels, outputs are register bits
  input wire smr_pkg::smr_modem_in_t modem_in,
  output smr_pkg::smr_modem_out_t modem_out,
  // address filter from the protocol engine
  input wire logic [15:0] rx_addr_field,
  output logic addr_match,
  // receive dma side from the protocol engine
  // one rx_xfer pulse per byte written to memory
  input wire logic rx_xfer,
  input wire logic rx_msg_end,
  output logic [17:0] rx_dma_addr,
  output logic rx_dma_ok
);
  import smr_pkg::*;

  // two-flop synchroniser for the asynchronous modem lines
  // the data set drives these pins with no relation to sys_clk, so only
  // the second stage may feed logic; the first may still be settling
  smr_modem_in_t sync1_q, sync1_d;
  smr_modem_in_t sync2_q, sync2_d;
  // last cycle's synchronised lines, for the change detector
  smr_modem_in_t prev_q, prev_d;

  // software registers
  // modem_out_q keeps only the writable bits; the rest are masked on write
  logic [15:0] modem_out_q, modem_out_d;
  logic [15:0] staddr_q, staddr_d;
  logic [15:0] mode_q, mode_d;
  smr_desc_t pri_q, pri_d;
  smr_desc_t sec_q, sec_d;
  // status flags
  // sticky flags except active_sec_q: hardware sets them, software clears them
  logic ds_change_q, ds_change_d;
  logic pri_done_q, pri_done_d;
  logic sec_done_q, sec_done_d;
  logic overflow_q, overflow_d;
  logic active_sec_q, active_sec_d;
  // bus handshake
  // one state register is enough: every access takes exactly two cycles
  smr_bus_st_t bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d; // read data, held until the next accepted read or write
  // address filter result, registered so the engine sees a clean level
  logic addr_match_q, addr_match_d;

  // decoded access
  // all combinational, derived from the bus inputs and the registers of this cycle
  logic [3:0] idx;
  logic mapped;
  logic wr_go;
  logic [15:0] wdata;
  logic [15:0] modem_word;
  logic edge_seen;
  // count of the descriptor now receiving
  logic [13:0] act_count;

  // register index is the word address; low two address bits are not present (word addressing)
  assign idx = avs_address[3:0];
  assign mapped = (avs_address[5:4] == 2'b00) && (idx >= SMR_IDX_MODEM) && (idx <= SMR_IDX_MODE);
  // write commits once, at the edge where waitrequest is seen low
  // the write and the completion of the transfer then fall on one edge,
  // so a master never sees its write land before the answer
  assign wr_go = avs_write && (bus_q == SMR_ST_DONE);
  // disabled byte lanes write zero rather than keep the old byte
  assign wdata = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00, avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

  // assembled modem word; unused bits tie to zero
  // inputs come from the second sync stage, outputs from the stored bits
  always_comb begin
    modem_word = SMR_RST_WORD;
    modem_word[SMR_B_USER_IN] = sync2_q.user_in;
    modem_word[SMR_B_CTS] = sync2_q.cts;
    modem_word[SMR_B_DCD] = sync2_q.dcd;
    modem_word[SMR_B_RI] = sync2_q.ri;
    modem_word[SMR_B_DSR] = sync2_q.dsr;
    modem_word = modem_word | (modem_out_q & SMR_MODEM_WMASK);
  end

  // edge detection looks only at the second stage, never the first
  // any difference, rising or falling, is one transition;
  // a pin already high at reset release flags once
  assign edge_seen = (sync2_q != prev_q);

  // outgoing modem lines follow the stored bits directly
  // modem_out_q is already a register, so the pins are glitch free
  assign modem_out.user_out = modem_out_q[SMR_B_USER_OUT];
  assign modem_out.dtr = modem_out_q[SMR_B_DTR];
  assign modem_out.dsrs = modem_out_q[SMR_B_DSRS];
  assign modem_out.rts = modem_out_q[SMR_B_RTS];

  // address filter: one-byte stations ignore the upper byte
  // the result lags the address field by one clock; a user must allow
  // that cycle between presenting the field and reading the match
  always_comb begin
    if (mode_q[SMR_B_ONE_BYTE]) begin
      // short address: the upper byte may hold anything
      addr_match_d = (rx_addr_field[7:0] == staddr_q[7:0]);
    end else begin
      // full sixteen-bit compare
      addr_match_d = (rx_addr_field == staddr_q);
    end
  end
  assign addr_match = addr_match_q;

  // active descriptor drives the dma address
  // primary and secondary alternate, so software refills one while the other fills
  assign act_count = active_sec_q ? sec_q.count : pri_q.count;
  assign rx_dma_addr = active_sec_q ? sec_q.addr : pri_q.addr;
  // room left in the active buffer; transfers with no room are dropped
  // the engine may still strobe rx_xfer while this is low; that byte is lost
  assign rx_dma_ok = (act_count != SMR_RST_COUNT);

  // synchroniser and edge history next values
  // plain shifts; no logic sits between the two stages
  always_comb begin
    sync1_d = modem_in;
    sync2_d = sync1_q;
    prev_d = sync2_q;
  end

  // register file, counters and flags next values
  // every value defaults to hold, so only the branches below change state
  always_comb begin
    modem_out_d = modem_out_q;
    staddr_d = staddr_q;
    mode_d = mode_q;
    pri_d = pri_q;
    sec_d = sec_q;
    ds_change_d = ds_change_q;
    pri_done_d = pri_done_q;
    sec_done_d = sec_done_q;
    overflow_d = overflow_q;
    active_sec_d = active_sec_q;
    // software writes first, so hardware events below win over clears
    // a clear that meets an event in the same cycle is simply lost
    if (wr_go && mapped) begin
      case (idx)
        // input bits and unused bits are read-only and ignored here
        SMR_IDX_MODEM: modem_out_d = wdata & SMR_MODEM_WMASK;
        SMR_IDX_STADDR: staddr_d = wdata;
        SMR_IDX_PRI_LO: pri_d.addr[15:0] = wdata;
        SMR_IDX_PRI_HI: begin
          pri_d.addr[17:16] = wdata[15:14];
          pri_d.count = wdata[13:0];
          pri_done_d = 1'b0;
        end
        SMR_IDX_SEC_LO: sec_d.addr[15:0] = wdata;
        SMR_IDX_SEC_HI: begin
          sec_d.addr[17:16] = wdata[15:14];
          sec_d.count = wdata[13:0];
          sec_done_d = 1'b0;
        end
        SMR_IDX_STATUS: begin
          // write one to clear the change and overflow flags; done flags clear on a count write
          if (wdata[SMR_B_DS_CHANGE]) begin
            ds_change_d = 1'b0;
          end
          if (wdata[SMR_B_OVERFLOW]) begin
            overflow_d = 1'b0;
          end
          // bit 3 selects the buffer the next byte goes to
          active_sec_d = wdata[SMR_B_ACTIVE_SEC];
        end
        SMR_IDX_MODE: mode_d = wdata;
        default: begin
          // read-only index: nothing to store
        end
      endcase
    end
    // any modem line transition sets the change flag
    // one flag for all lines; software reads the word to see which moved
    if (edge_seen) begin
      ds_change_d = 1'b1;
    end
    // each transfer decrements the active count and advances the address
    // a full buffer drops the byte and only raises overflow; count stays zero
    if (rx_xfer) begin
      if (act_count == SMR_RST_COUNT) begin
        overflow_d = 1'b1;
      end else if (active_sec_q) begin
        sec_d.count = sec_q.count - SMR_CNT_ONE;
        sec_d.addr = sec_q.addr + 18'h00001;
      end else begin
        pri_d.count = pri_q.count - SMR_CNT_ONE;
        pri_d.addr = pri_q.addr + 18'h00001;
      end
    end
    // end of message marks the active buffer done and swaps buffers
    // done of the other buffer is left alone; its count write clears it
    if (rx_msg_end) begin
      if (active_sec_q) begin
        sec_done_d = 1'b1;
      end else begin
        pri_done_d = 1'b1;
      end
      active_sec_d = ~active_sec_q;
    end
  end

  // bus handshake and read data next values
  // read data is latched in the wait cycle and stands through the answer
  always_comb begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    case (bus_q)
      // idle: waitrequest is high, a request is taken at the next edge
      SMR_ST_IDLE: begin
        // one wait state: latch read data, then release waitrequest
        // writes are not committed here; they wait for the answer cycle
        if (avs_read || avs_write) begin
          bus_d = SMR_ST_DONE;
          rdata_d = 32'h0000_0000;
          if (avs_read && mapped) begin
            case (idx)
              SMR_IDX_MODEM: rdata_d[15:0] = modem_word;
              SMR_IDX_STADDR: rdata_d[15:0] = staddr_q;
              SMR_IDX_PRI_LO: rdata_d[15:0] = pri_q.addr[15:0];
              SMR_IDX_PRI_HI: rdata_d[15:0] = {pri_q.addr[17:16], pri_q.count};
              SMR_IDX_SEC_LO: rdata_d[15:0] = sec_q.addr[15:0];
              SMR_IDX_SEC_HI: rdata_d[15:0] = {sec_q.addr[17:16], sec_q.count};
              SMR_IDX_STATUS: begin
                // flags read live; reading never clears them
                rdata_d[SMR_B_PRI_DONE] = pri_done_q;
                rdata_d[SMR_B_SEC_DONE] = sec_done_q;
                rdata_d[SMR_B_OVERFLOW] = overflow_q;
                rdata_d[SMR_B_ACTIVE_SEC] = active_sec_q;
                rdata_d[SMR_B_DS_CHANGE] = ds_change_q;
              end
              SMR_IDX_MODE: rdata_d[15:0] = mode_q;
              default: rdata_d = 32'h0000_0000;
            endcase
          end
        end
      end
      // answer cycle: the master releases here, so always return to idle
      SMR_ST_DONE: bus_d = SMR_ST_IDLE;
      default: bus_d = SMR_ST_IDLE;
    endcase
  end

  // waitrequest high in the idle cycle of a request, low in the done cycle
  // it is high with no request too, so a master never sees a stale answer
  assign avs_waitrequest = (bus_q == SMR_ST_IDLE);
  assign avs_readdata = rdata_q;
  // unmapped addresses answer with slave error
  // the response follows the held address, so it stands through the answer
  assign avs_response = mapped ? 2'b00 : 2'b10;

  // synchroniser and edge history registers
  // reset to zero, the idle level of the lines; a line already high at reset release flags one edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end

  // register file, descriptor and flag registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      modem_out_q <= SMR_RST_WORD;
      staddr_q <= SMR_RST_WORD;
      mode_q <= SMR_RST_WORD;
      pri_q <= '0;
      sec_q <= '0;
      ds_change_q <= 1'b0;
      pri_done_q <= 1'b0;
      sec_done_q <= 1'b0;
      overflow_q <= 1'b0;
      active_sec_q <= 1'b0;
    end else begin
      modem_out_q <= modem_out_d;
      staddr_q <= staddr_d;
      mode_q <= mode_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      ds_change_q <= ds_change_d;
      pri_done_q <= pri_done_d;
      sec_done_q <= sec_done_d;
      overflow_q <= overflow_d;
      active_sec_q <= active_sec_d;
    end
  end

  // bus handshake registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= SMR_ST_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_q <= bus_d;
      rdata_q <= rdata_d;
    end
  end

  // address filter register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_match_q <= 1'b0;
    end else begin
      addr_match_q <= addr_match_d;
    end
  end
endmodule // smr_regs

// [src/smr_pkg.sv]
// package: register map, field positions and carrier types for the modem and receive buffer register bank
package smr_pkg;
  // word offsets on the avalon bus (byte address = index * 4)
  localparam logic [3:0] SMR_IDX_MODEM = 4'h4;
  localparam logic [3:0] SMR_IDX_STADDR = 4'h5;
  localparam logic [3:0] SMR_IDX_PRI_LO = 4'h6;
  localparam logic [3:0] SMR_IDX_PRI_HI = 4'h7;
  localparam logic [3:0] SMR_IDX_SEC_LO = 4'h8;
  localparam logic [3:0] SMR_IDX_SEC_HI = 4'h9;
  localparam logic [3:0] SMR_IDX_STATUS = 4'ha;
  localparam logic [3:0] SMR_IDX_MODE = 4'hb;
  // modem register field positions
  localparam int SMR_B_USER_IN = 2;
  localparam int SMR_B_CTS = 4;
  localparam int SMR_B_DCD = 5;
  localparam int SMR_B_RI = 6;
  localparam int SMR_B_DSR = 7;
  localparam int SMR_B_USER_OUT = 8;
  localparam int SMR_B_DTR = 9;
  localparam int SMR_B_DSRS = 10;
  localparam int SMR_B_RTS = 12;
  // writable modem bits: 8, 9, 10, 12
  localparam logic [15:0] SMR_MODEM_WMASK = 16'h1700;
  // status register field positions
  localparam int SMR_B_DS_CHANGE = 6;
  localparam int SMR_B_PRI_DONE = 0;
  localparam int SMR_B_SEC_DONE = 1;
  localparam int SMR_B_OVERFLOW = 2;
  localparam int SMR_B_ACTIVE_SEC = 3;
  // mode register: bit 0 one-byte address
  localparam int SMR_B_ONE_BYTE = 0;
  // reset values
  localparam logic [15:0] SMR_RST_WORD = 16'h0000;
  localparam logic [13:0] SMR_RST_COUNT = 14'h0000;
  // byte count and address widths
  localparam int SMR_CNT_W = 14;
  localparam int SMR_ADDR_W = 18;
  localparam logic [13:0] SMR_CNT_ONE = 14'h0001;

  // modem input lines from the data set
  typedef struct packed {
    logic user_in;
    logic cts;
    logic dcd;
    logic ri;
    logic dsr;
  } smr_modem_in_t;

  // modem output lines toward the data set
  typedef struct packed {
    logic user_out;
    logic dtr;
    logic dsrs;
    logic rts;
  } smr_modem_out_t;

  // one receive buffer descriptor
  typedef struct packed {
    logic [SMR_ADDR_W-1:0] addr;
    logic [SMR_CNT_W-1:0] count;
  } smr_desc_t;

  // bus slave state
  typedef enum logic [1:0] {
    SMR_ST_IDLE = 2'b01,
    SMR_ST_DONE = 2'b10
  } smr_bus_st_t;
endpackage

// [test/smr_regs_properties.sv]
// checker: bus handshake, modem output and dma stepping properties of smr_regs
`timescale 1ns/1ns
module smr_regs_properties import smr_pkg::*; (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire smr_modem_in_t modem_in,
  input wire smr_modem_out_t modem_out,
  input wire logic [15:0] rx_addr_field,
  input wire logic addr_match,
  input wire logic rx_xfer,
  input wire logic rx_msg_end,
  input wire logic [17:0] rx_dma_addr,
  input wire logic rx_dma_ok
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // modem register write completing at this edge, high lane enabled
  logic mw;
  assign mw = avs_write && !avs_waitrequest && avs_address == {2'b00, SMR_IDX_MODEM} && avs_byteenable[1];
  // quiet dma step: no message end and no register write alongside
  logic step;
  assign step = rx_xfer && !rx_msg_end && !avs_write;
  req_taken_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("answer stood longer than one cycle");
  user_out_a: assert property (mw |=> modem_out.user_out == $past(avs_writedata[8]))
    else $error("user output does not follow bit 8");
  dtr_out_a: assert property (mw |=> modem_out.dtr == $past(avs_writedata[9]))
    else $error("terminal ready does not follow bit 9");
  rate_out_a: assert property (mw |=> modem_out.dsrs == $past(avs_writedata[10]))
    else $error("rate selector does not follow bit 10");
  rts_out_a: assert property (mw |=> modem_out.rts == $past(avs_writedata[12]))
    else $error("request to send does not follow bit 12");
  unused_zero_a: assert property (!avs_waitrequest && avs_read && avs_address == 6'h4 |->
    (avs_readdata & 32'hffffe80b) == 32'h0)
    else $error("unused modem bits not zero");
  dma_step_a: assert property (step && rx_dma_ok |=> rx_dma_addr == $past(rx_dma_addr) + 18'h1)
    else $error("dma address did not advance");
  drop_full_a: assert property (step && !rx_dma_ok |=> $stable(rx_dma_addr))
    else $error("transfer into full buffer not dropped");
  cover property (mw);
  cover property (rx_xfer && !rx_dma_ok);
  cover property (!avs_waitrequest && avs_response == 2'b10);
endmodule // smr_regs_properties

// [test/smr_modem_model.sv]
// modem model: data set lines set by the bench, data set ready answers terminal ready
`timescale 1ns/1ns
module smr_modem_model import smr_pkg::*; (
  input wire logic sys_clk,
  input wire logic [3:0] line_cmd,
  input wire smr_modem_out_t modem_out,
  output smr_modem_in_t modem_in
);
  // ready answer one clock late, like a slow data set
  logic dsr_q = 1'b0;
  always_ff @(posedge sys_clk) begin
    dsr_q <= modem_out.dtr;
  end
  // order matches user_in, cts, dcd, ri, dsr
  assign modem_in = {line_cmd, dsr_q};
endmodule // smr_modem_model

// [test/test_smr_regs.sv]
// testbench: register bus, modem lines, address filter and receive dma of smr_regs
`timescale 1ns/1ns
module test_smr_regs import smr_pkg::*;;
  logic sys_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, rx_xfer = 1'b0, rx_msg_end = 1'b0;
  logic [5:0] avs_address = 6'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, addr_match, rx_dma_ok;
  logic [1:0] avs_response, rsp;
  logic [3:0] line_cmd = 4'h0;
  logic [15:0] rx_addr_field = 16'h0;
  logic [17:0] rx_dma_addr;
  smr_modem_in_t modem_in;
  smr_modem_out_t modem_out;
  int n_fail = 0, n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  smr_regs dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .modem_in(modem_in), .modem_out(modem_out),
    .rx_addr_field(rx_addr_field), .addr_match(addr_match), .rx_xfer(rx_xfer), .rx_msg_end(rx_msg_end),
    .rx_dma_addr(rx_dma_addr), .rx_dma_ok(rx_dma_ok));
  smr_modem_model modem_u (.sys_clk(sys_clk), .line_cmd(line_cmd), .modem_out(modem_out), .modem_in(modem_in));
  // compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0, d};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      k++;
      @(posedge sys_clk);
    end
    if (k >= 50) begin
      n_fail++;
      $display("FAIL bus expected waitrequest low seen timeout");
    end
    q = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // present an address field, let the registered match settle, compare
  task match(input string nm, input logic [15:0] f, input logic e);
    @(posedge sys_clk);
    rx_addr_field <= f;
    repeat (2) @(negedge sys_clk);
    chk(nm, {31'h0, e}, {31'h0, addr_match});
  endtask
  // one-cycle pulse on a dma strobe, then settle
  task pulse(input logic m);
    @(posedge sys_clk);
    if (m) begin
      rx_msg_end <= 1'b1;
    end else begin
      rx_xfer <= 1'b1;
    end
    @(posedge sys_clk);
    rx_msg_end <= 1'b0;
    rx_xfer <= 1'b0;
    @(negedge sys_clk);
  endtask
  // outputs: all ones, then each writable bit alone
  task t_out;
    int i;
    bus(1, 6'h4, 16'hffff);
    repeat (5) @(posedge sys_clk);
    chk("modem_out all", 32'hf, 32'(modem_out));
    bus(0, 6'h4, 16'h0);
    chk("modem read", 32'h1780, q);
    for (i = 8; i < 13; i++) begin
      if (i != 11) begin
        bus(1, 6'h4, 16'h1 << i);
        @(negedge sys_clk);
        chk("modem_out bit", {28'h0, i == 8, i == 9, i == 10, i == 12}, 32'(modem_out));
      end
    end
  endtask
  // each input's rising edge shows in its bit and raises the change flag
  task t_in;
    int j;
    int pos[5] = '{2, 4, 5, 6, 7};
    bus(1, 6'h4, 16'h0);
    for (j = 0; j < 5; j++) begin
      repeat (5) @(posedge sys_clk);
      bus(1, {2'b00, SMR_IDX_STATUS}, 16'h40);
      bus(0, {2'b00, SMR_IDX_STATUS}, 16'h0);
      chk("change clear", 32'h0, q & 32'h40);
      if (j < 4) begin
        line_cmd <= 4'h8 >> j;
      end else begin
        bus(1, 6'h4, 16'h200);
      end
      repeat (5) @(posedge sys_clk);
      bus(0, 6'h4, 16'h0);
      chk("modem in", (32'h1 << pos[j]) | (j == 4 ? 32'h200 : 32'h0), q);
      bus(0, {2'b00, SMR_IDX_STATUS}, 16'h0);
      chk("change set", 32'h40, q & 32'h40);
      line_cmd <= 4'h0;
    end
  endtask
  // station address filter, two-byte and one-byte
  task t_addr;
    bus(1, 6'h5, 16'h12ab);
    bus(1, {2'b00, SMR_IDX_MODE}, 16'h0);
    bus(0, 6'h5, 16'h0);
    chk("staddr", 32'h12ab, q);
    match("match", 16'h12ab, 1'b1);
    match("mismatch", 16'h55ab, 1'b0);
    bus(1, {2'b00, SMR_IDX_MODE}, 16'h1);
    match("low byte", 16'h55ab, 1'b1);
    match("low byte diff", 16'h12cd, 1'b0);
  endtask
  // receive descriptors: stepping, overflow, done flags, switch
  task t_dma;
    bus(1, 6'h6, 16'h1000);
    bus(1, 6'h7, 16'h8002);
    bus(1, 6'h8, 16'h0300);
    bus(1, 6'h9, 16'hc005);
    chk("pri addr", 32'h21000, 32'(rx_dma_addr));
    repeat (3) pulse(0);
    chk("pri step", 32'h21002, 32'(rx_dma_addr));
    bus(0, 6'h7, 16'h0);
    chk("pri count", 32'h8000, q);
    pulse(1);
    bus(0, {2'b00, SMR_IDX_STATUS}, 16'h0);
    chk("ovf done", 32'hd, q & 32'hf);
    chk("sec addr", 32'h30300, 32'(rx_dma_addr));
    bus(1, 6'h7, 16'h8004);
    bus(0, {2'b00, SMR_IDX_STATUS}, 16'h0);
    chk("pri done clr", 32'h0, q & 32'h1);
    pulse(0);
    pulse(1);
    bus(0, 6'h9, 16'h0);
    chk("sec count", 32'hc004, q);
    bus(0, {2'b00, SMR_IDX_STATUS}, 16'h0);
    chk("sec done", 32'h2, q & 32'h2);
    bus(1, 6'h9, 16'hc005);
    bus(0, {2'b00, SMR_IDX_STATUS}, 16'h0);
    chk("sec done clr", 32'h0, q & 32'h2);
    bus(1, {2'b00, SMR_IDX_STATUS}, 16'h000c);
    bus(0, {2'b00, SMR_IDX_STATUS}, 16'h0);
    chk("ovf clr sel", 32'h8, q & 32'hc);
    chk("sec select", 32'h30301, 32'(rx_dma_addr));
    bus(0, 6'h3f, 16'h0);
    chk("unmapped", 32'h2, 32'(rsp));
  endtask
  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    n_fail++;
    $display("FAIL watchdog expected finish seen timeout");
    test_done();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_out();
    t_in();
    t_addr();
    t_dma();
    test_done();
  end
endmodule // test_smr_regs
bind smr_regs smr_regs_properties props_u (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .modem_in(modem_in), .modem_out(modem_out), .rx_addr_field(rx_addr_field), .addr_match(addr_match),
  .rx_xfer(rx_xfer), .rx_msg_end(rx_msg_end), .rx_dma_addr(rx_dma_addr), .rx_dma_ok(rx_dma_ok));
